// ==== adcc_controller.sv ====
// Purpose: Controlling party: register file, timer and safe sequencing
// Assumes: AXI4-Lite slave with 32-bit data, one access of each kind at once
// Notes: Enable, power, start, recovery and clock source changes reach the link in safe orders; timer triggers ignore busy
`timescale 1ns/10ps
module adcc_controller import adcc_pkg::*; #(
    parameter int PeriodW = 16
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq,
    // Link to converter
    adcc_if.ctrl link
);
    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    adcc_seq_t seq_r;
    logic [7:0] awAddr_r, arAddr;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic awHave_r, wHave_r, bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [19:0] ctrl_r;
    logic [PeriodW-1:0] period_r, timer_r;
    logic [3:0] irqStat_r, irqMask_r;
    logic [15:0] result_r;
    logic startPend_r, recoverPend_r, haltPrev_r;
    logic enc_r, on_r, sc_r, tt_r, clkOff_r;
    logic [1:0] clkSel_r;

    // Write decode
    wire writeGo = awHave_r && wHave_r && !bvalid_r;
    wire [7:0] wAddr = {awAddr_r[7:2], 2'h0};
    wire [31:0] wMerged = merge({12'h000, ctrl_r}, wData_r, wStrb_r);
    wire [31:0] wBits = merge(32'h00000000, wData_r, wStrb_r);
    wire wrCtrl = writeGo && wAddr == OFS_CTRL;
    wire wrCmd = writeGo && wAddr == OFS_CMD;
    wire wrPeriod = writeGo && wAddr == OFS_PERIOD;
    wire wrStat = writeGo && wAddr == OFS_IRQ_STAT;
    wire wrMask = writeGo && wAddr == OFS_IRQ_MASK;
    wire wMapped = wrCtrl || wrCmd || wrPeriod || wrStat || wrMask;
    // Read decode
    wire readGo = arvalid && !rvalid_r;
    assign arAddr = {araddr[7:2], 2'h0};
    wire [31:0] statusWord = {26'h0000000, startPend_r || sc_r, on_r, enc_r, link.hung,
        link.halted, link.conversionInProgress};
    wire rMapped = arAddr == OFS_CTRL || arAddr == OFS_PERIOD || arAddr == OFS_STATUS
        || arAddr == OFS_IRQ_STAT || arAddr == OFS_IRQ_MASK || arAddr == OFS_RESULT
        || arAddr == OFS_CMD;
    wire [31:0] rWord = arAddr == OFS_CTRL ? {12'h000, ctrl_r}
        : arAddr == OFS_PERIOD ? 32'(period_r)
        : arAddr == OFS_STATUS ? statusWord
        : arAddr == OFS_IRQ_STAT ? {28'h0000000, irqStat_r}
        : arAddr == OFS_IRQ_MASK ? {28'h0000000, irqMask_r}
        : arAddr == OFS_RESULT ? {16'h0000, result_r} : 32'h00000000;
    // Events and applied settings
    wire [3:0] events = {link.triggerOverflowFlag, link.halted && !haltPrev_r,
        link.dmaRequest, link.resultValid};
    wire timerHit = ctrl_r[CTL_TIMER] && timer_r >= period_r;
    wire [3:0] refSel = ctrl_r[CTL_REFSEL +: 4];
    wire unbuffered = !refSel[0] && (refSel <= 4'h6 || refSel >= 4'hC);
    wire [1:0] wantSel = ctrl_r[CTL_CLKSEL +: 2];
    wire idleLink = !enc_r && !link.conversionInProgress;

    // AXI handshakes
    assign awready = !awHave_r && !bvalid_r;
    assign wready = !wHave_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // AXI channel state
    always_ff @(posedge clock) begin
        if (reset) begin
            {awHave_r, wHave_r, bvalid_r, rvalid_r} <= 4'h0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            if (awvalid && awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= awaddr;
            end else if (writeGo) begin
                awHave_r <= 1'b0;
            end
            if (wvalid && wready) begin
                wHave_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (writeGo) begin
                wHave_r <= 1'b0;
            end
            if (writeGo) begin
                bvalid_r <= 1'b1;
                bresp_r <= wMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
            if (readGo) begin
                rvalid_r <= 1'b1;
                rdata_r <= rWord;
                rresp_r <= rMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Software registers and interrupt status; a new event wins over its clear
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_r <= CTRL_RESET;
            period_r <= PeriodW'(PERIOD_RESET);
            irqStat_r <= 4'h0;
            irqMask_r <= 4'h0;
            result_r <= 16'h0000;
            haltPrev_r <= 1'b0;
        end else begin
            if (wrCtrl) ctrl_r <= wMerged[19:0];
            if (wrPeriod) period_r <= PeriodW'(merge(32'(period_r), wData_r, wStrb_r));
            if (wrMask) irqMask_r <= wBits[3:0];
            irqStat_r <= (irqStat_r & ~(wrStat ? wBits[3:0] : 4'h0)) | events;
            if (link.resultValid) result_r <= {link.resultChannel, link.result};
            haltPrev_r <= link.halted;
        end
    end

    // Timer trigger source and clock source changes
    always_ff @(posedge clock) begin
        if (reset) begin
            timer_r <= '0;
            clkSel_r <= 2'h0;
            clkOff_r <= 1'b0;
        end else begin
            timer_r <= (!ctrl_r[CTL_TIMER] || timerHit) ? '0 : timer_r + 1'b1; // R7
            if (wantSel != clkSel_r && clkOff_r) begin
                clkOff_r <= 1'b0; // R12
            end else if (wantSel != clkSel_r) begin
                clkSel_r <= wantSel; // R12
            end else begin
                clkOff_r <= ctrl_r[CTL_CLKOFF];
            end
        end
    end

    // Enable, power, start and trigger sequencing
    always_ff @(posedge clock) begin
        if (reset) begin
            seq_r <= CS_IDLE;
            {enc_r, on_r, sc_r, tt_r} <= 4'h0;
            startPend_r <= 1'b0;
            recoverPend_r <= 1'b0;
        end else begin
            sc_r <= 1'b0;
            tt_r <= 1'b0;
            if (wrCmd && wBits[CMD_START]) startPend_r <= 1'b1;
            if (wrCmd && wBits[CMD_RECOVER]) recoverPend_r <= 1'b1;
            unique case (seq_r)
                CS_IDLE: begin
                    enc_r <= ctrl_r[CTL_ENABLE] && ctrl_r[CTL_POWER] && on_r; // R10
                    if (ctrl_r[CTL_POWER] != on_r && idleLink) begin
                        on_r <= ctrl_r[CTL_POWER]; // R10
                    end
                    if (recoverPend_r) begin
                        recoverPend_r <= wrCmd && wBits[CMD_RECOVER];
                        enc_r <= 1'b0; // R5
                        on_r <= 1'b0; // R5
                        seq_r <= CS_REC_OFF;
                    end else if (timerHit && enc_r && on_r) begin
                        enc_r <= 1'b0; // R14
                        seq_r <= CS_TOGGLE;
                    end else if (startPend_r && enc_r && !link.conversionInProgress) begin
                        sc_r <= 1'b1; // R6
                        startPend_r <= wrCmd && wBits[CMD_START];
                    end
                end
                CS_TOGGLE: begin
                    enc_r <= 1'b1; // R14
                    tt_r <= 1'b1;
                    seq_r <= CS_IDLE;
                end
                CS_REC_OFF: begin
                    on_r <= 1'b1; // R5
                    seq_r <= CS_REC_ON;
                end
                CS_REC_ON: begin
                    enc_r <= 1'b1; // R5
                    seq_r <= CS_IDLE;
                end
            endcase
        end
    end

    // Link outputs; unbuffered references force pulse sampling
    assign link.conversionEnable = enc_r;
    assign link.converterPowerOn = on_r;
    assign link.startConversion = sc_r;
    assign link.timerTrigger = tt_r;
    assign link.samplePulseMode = ctrl_r[CTL_PULSE] || unbuffered; // R13
    assign link.sequenceModeField = ctrl_r[CTL_SEQ +: 2];
    assign link.converterClockSelect = clkSel_r;
    assign link.converterClockDivider = ctrl_r[CTL_DIV +: 3];
    assign link.subsystemClockOff = clkOff_r;
    assign link.referenceSelect = refSel;
    assign link.lastChannel = ctrl_r[CTL_LASTCH +: 4];
    assign irq = |(irqStat_r & irqMask_r);
endmodule

// ==== adcc_pkg.sv ====
// Purpose: Shared constants and types of the converter trigger control pair
// Assumes: One clock domain; register words are 32 bits
// Notes: Converter timing is counted in divided converter clock ticks
package adcc_pkg;
    // Sequence mode codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_REP_SINGLE = 2'h2;
    localparam logic [1:0] MODE_REP_SEQ = 2'h3;
    localparam logic [1:0] CLKSEL_SUBSYS = 2'h3;
    // Converter timing in converter clock ticks
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
    localparam logic [3:0] CONV_TICKS = 4'hD;
    localparam int MIN_EXT_SAMPLE = 6;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    // Control word fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_POWER = 1;
    localparam int CTL_PULSE = 2;
    localparam int CTL_TIMER = 3;
    localparam int CTL_SEQ = 4;
    localparam int CTL_CLKSEL = 6;
    localparam int CTL_DIV = 8;
    localparam int CTL_CLKOFF = 11;
    localparam int CTL_REFSEL = 12;
    localparam int CTL_LASTCH = 16;
    localparam logic [19:0] CTRL_RESET = 20'h00000;
    // Command word fields
    localparam int CMD_START = 0;
    localparam int CMD_RECOVER = 1;
    // Interrupt status fields
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DMA = 1;
    localparam int IRQ_HALT = 2;
    localparam int IRQ_OVF = 3;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Converter state
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_SAMPLE = 4'h2, ST_CONVERT = 4'h4, ST_HALT = 4'h8
    } adcc_conv_t;
    // Controller sequencing state
    typedef enum logic [3:0] {
        CS_IDLE = 4'h1, CS_TOGGLE = 4'h2, CS_REC_OFF = 4'h4, CS_REC_ON = 4'h8
    } adcc_seq_t;
endpackage

// ==== adcc_if.sv ====
// Purpose: Link between the converter and its controlling party
// Assumes: Both ends share the system clock
// Notes: startConversion, timerTrigger, resultValid, dmaRequest and triggerOverflowFlag are one-cycle pulses; the rest are levels
`timescale 1ns/10ps
interface adcc_if;
    logic conversionEnable;
    logic converterPowerOn;
    logic startConversion;
    logic timerTrigger;
    logic samplePulseMode;
    logic [1:0] sequenceModeField;
    logic [1:0] converterClockSelect;
    logic [2:0] converterClockDivider;
    logic subsystemClockOff;
    logic [3:0] referenceSelect;
    logic [3:0] lastChannel;
    logic conversionInProgress;
    logic dmaRequest;
    logic triggerOverflowFlag;
    logic resultValid;
    logic [11:0] result;
    logic [3:0] resultChannel;
    logic halted;
    logic hung;
    modport ctrl (
        output conversionEnable, converterPowerOn, startConversion, timerTrigger,
        output samplePulseMode, sequenceModeField, converterClockSelect,
        output converterClockDivider, subsystemClockOff, referenceSelect, lastChannel,
        input conversionInProgress, dmaRequest, triggerOverflowFlag, resultValid,
        input result, resultChannel, halted, hung
    );
    modport dev (
        input conversionEnable, converterPowerOn, startConversion, timerTrigger,
        input samplePulseMode, sequenceModeField, converterClockSelect,
        input converterClockDivider, subsystemClockOff, referenceSelect, lastChannel,
        output conversionInProgress, dmaRequest, triggerOverflowFlag, resultValid,
        output result, resultChannel, halted, hung
    );
endinterface

// ==== adcc_device.sv ====
// Purpose: Converter conversion control with its recorded lock-up behaviour
// Assumes: Controller inputs synchronous to clock; triggers act on rising edges
// Notes: A halt holds until the recovery sequence; a clock hang until reset
`timescale 1ns/10ps
// Notes on behaviour
// R1: Timer trigger without enable toggle halts converter
// R2: Trigger while busy in multi modes halts
// R3: Starts come from start bit or timer
// R4: Overflow flag misses halting overruns
// R5: Recovery: both off, power on, enable on
// R6: Manual start only after busy reads idle
// R7: Timer period exceeds sample plus conversion; the controller uses period_r unchecked
// R8: DMA request after every single conversion
// R9: Power toggle while busy halts multi modes
// R10: Stop: clear enable, await idle, then power
// R11: Subsystem clock change with odd divider hangs
// R12: Clear clock-off before changing clock source
// R13: Unbuffered extended sampling needs six clocks
// R14: Toggle enable before every external trigger
// R15: Busy from accepted trigger to final conversion
module adcc_device import adcc_pkg::*; #(
    parameter logic [3:0] SampleTicks = SAMPLE_TICKS,
    parameter logic [3:0] ConvTicks = CONV_TICKS
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // Link to controller
    adcc_if.dev link,
    // Analog front end sample value
    input wire logic [11:0] analogIn
);
    adcc_conv_t state_r, state_nxt;
    logic [2:0] divCnt_r;
    logic [3:0] tickCnt_r, tickCnt_nxt;
    logic [3:0] chan_r, chan_nxt;
    logic [1:0] recStage_r, recStage_nxt;
    logic prevEnc_r, prevOn_r, prevSc_r, prevTt_r;
    logic [1:0] prevSel_r;
    logic needToggle_r, needToggle_nxt;
    logic hung_r;
    logic [11:0] sample_r, result_r;
    logic [3:0] resChan_r;
    logic done_r, ovf_r;

    // Converter clock tick from the divider
    wire tick = divCnt_r == link.converterClockDivider;
    wire oddDiv = link.converterClockDivider == 3'h2 || link.converterClockDivider == 3'h4
        || link.converterClockDivider == 3'h6;
    wire hangNow = prevSel_r == CLKSEL_SUBSYS && link.subsystemClockOff && oddDiv
        && link.converterClockSelect != prevSel_r; // R11
    // Trigger edges and mode decode
    wire scRise = link.startConversion && !prevSc_r;
    wire ttRise = link.timerTrigger && !prevTt_r;
    wire trigRise = scRise || ttRise; // R3
    wire ready = link.conversionEnable && link.converterPowerOn && !hung_r;
    wire [1:0] mode = link.sequenceModeField;
    wire multi = mode != MODE_SINGLE;
    wire seqMode = mode == MODE_SEQ || mode == MODE_REP_SEQ;
    wire busy = state_r == ST_SAMPLE || state_r == ST_CONVERT;
    wire onToggle = link.converterPowerOn != prevOn_r;
    wire encFall = prevEnc_r && !link.conversionEnable;
    wire srcLevel = link.startConversion || link.timerTrigger;
    wire lastChan = !seqMode || chan_r == link.lastChannel;
    wire sampleEnd = tick && (link.samplePulseMode ? tickCnt_r == SampleTicks - 4'h1 : !srcLevel);
    wire convEnd = state_r == ST_CONVERT && tick && tickCnt_r == ConvTicks - 4'h1;
    wire finalEnd = convEnd && lastChan && (mode == MODE_SINGLE || mode == MODE_SEQ
        || !link.conversionEnable);

    // Next state of the conversion sequencer
    always_comb begin
        state_nxt = state_r;
        tickCnt_nxt = tick ? tickCnt_r + 4'h1 : tickCnt_r;
        chan_nxt = chan_r;
        recStage_nxt = recStage_r;
        needToggle_nxt = needToggle_r;
        if (encFall) begin
            needToggle_nxt = 1'b0; // R1
        end
        unique case (state_r)
            ST_IDLE: begin
                if (ready && trigRise) begin
                    if (ttRise && needToggle_nxt) begin
                        state_nxt = ST_HALT; // R1
                    end else begin
                        state_nxt = ST_SAMPLE; // R3
                        tickCnt_nxt = 4'h0;
                        chan_nxt = 4'h0;
                    end
                end
            end
            ST_SAMPLE, ST_CONVERT: begin
                if (multi && (trigRise || onToggle)) begin
                    state_nxt = ST_HALT; // R2 R9
                end else if (!link.converterPowerOn) begin
                    state_nxt = ST_IDLE;
                end else if (state_r == ST_SAMPLE && sampleEnd) begin
                    state_nxt = ST_CONVERT;
                    tickCnt_nxt = 4'h0;
                end else if (finalEnd) begin
                    state_nxt = ST_IDLE; // R15
                    needToggle_nxt = mode == MODE_SINGLE || mode == MODE_SEQ; // R1
                end else if (convEnd) begin
                    state_nxt = ST_SAMPLE;
                    tickCnt_nxt = 4'h0;
                    chan_nxt = lastChan ? 4'h0 : chan_r + 4'h1;
                end
            end
            ST_HALT: begin
                recStage_nxt = 2'h0;
                if (recStage_r == 2'h0 && !link.conversionEnable && !link.converterPowerOn) begin
                    recStage_nxt = 2'h1; // R5
                end else if (recStage_r == 2'h1) begin
                    recStage_nxt = link.conversionEnable ? 2'h0
                        : (link.converterPowerOn ? 2'h2 : 2'h1); // R5
                end else if (recStage_r == 2'h2) begin
                    recStage_nxt = !link.converterPowerOn ? 2'h1
                        : (link.conversionEnable ? 2'h0 : 2'h2);
                    if (link.converterPowerOn && link.conversionEnable) begin
                        state_nxt = ST_IDLE; // R5
                        needToggle_nxt = 1'b0;
                    end
                end
            end
        endcase
        if (hung_r || hangNow) begin
            state_nxt = ST_IDLE; // R11
        end
    end

    // Sequencer and edge history registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_IDLE;
            divCnt_r <= 3'h0;
            tickCnt_r <= 4'h0;
            chan_r <= 4'h0;
            recStage_r <= 2'h0;
            needToggle_r <= 1'b0;
            {prevEnc_r, prevOn_r, prevSc_r, prevTt_r} <= 4'h0;
            prevSel_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            divCnt_r <= (tick || hung_r) ? 3'h0 : divCnt_r + 3'h1;
            tickCnt_r <= tickCnt_nxt;
            chan_r <= chan_nxt;
            recStage_r <= recStage_nxt;
            needToggle_r <= needToggle_nxt;
            {prevEnc_r, prevOn_r} <= {link.conversionEnable, link.converterPowerOn};
            {prevSc_r, prevTt_r} <= {link.startConversion, link.timerTrigger};
            prevSel_r <= link.converterClockSelect;
        end
    end

    // Clock hang latch: only a reset releases it
    always_ff @(posedge clock) begin
        if (reset) begin
            hung_r <= 1'b0;
        end else if (hangNow) begin
            hung_r <= 1'b1; // R11
        end
    end

    // Sample capture, result and per-conversion strobes
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_r <= 12'h000;
            result_r <= 12'h000;
            resChan_r <= 4'h0;
            done_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            if (state_r == ST_SAMPLE && state_nxt == ST_CONVERT) begin
                sample_r <= analogIn;
            end
            done_r <= convEnd && state_nxt != ST_HALT && !hangNow; // R8
            if (convEnd && state_nxt != ST_HALT && !hangNow) begin
                result_r <= sample_r;
                resChan_r <= chan_r;
            end
            ovf_r <= busy && !multi && trigRise; // R4
        end
    end

    // Link outputs
    assign link.conversionInProgress = busy; // R15
    assign link.dmaRequest = done_r; // R8
    assign link.resultValid = done_r;
    assign link.result = result_r;
    assign link.resultChannel = resChan_r;
    assign link.triggerOverflowFlag = ovf_r; // R4
    assign link.halted = state_r == ST_HALT;
    assign link.hung = hung_r;
endmodule

// ==== adcc_link_checker.sv ====
// Purpose: Link checks between the converter and its controlling party
// Assumes: One clock, synchronous active high reset
// Notes: Watches the interface signals only
`timescale 1ns/10ps
module adcc_link_checker import adcc_pkg::*; (
    // System
    input wire logic clock,
    input wire logic reset,
    // Controller outputs
    input wire logic conversionEnable,
    input wire logic converterPowerOn,
    input wire logic startConversion,
    input wire logic timerTrigger,
    input wire logic [1:0] sequenceModeField,
    // Converter outputs
    input wire logic conversionInProgress,
    input wire logic dmaRequest,
    input wire logic triggerOverflowFlag,
    input wire logic resultValid,
    input wire logic halted,
    input wire logic hung
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Start acceptance and busy span
    start_busy_a: assert property ($rose(startConversion) && conversionEnable && converterPowerOn
        && !conversionInProgress && !halted && !hung |=> conversionInProgress) else $error("no busy");
    busy_end_a: assert property ($fell(conversionInProgress) |-> dmaRequest || halted || hung
        || !converterPowerOn || !$past(converterPowerOn)) else $error("busy ended early");
    dma_result_a: assert property (dmaRequest |-> resultValid && $past(conversionInProgress))
        else $error("dma without result");
    // Faulty behaviour: multi-mode halts, single-mode overflow flag, halt and hang holding
    multi_halt_a: assert property (conversionInProgress && sequenceModeField != MODE_SINGLE
        && ($rose(startConversion) || $rose(timerTrigger)) |=> halted) else $error("no halt");
    power_halt_a: assert property (conversionInProgress && sequenceModeField != MODE_SINGLE
        && $changed(converterPowerOn) |=> halted) else $error("no power halt");
    ovf_single_a: assert property (triggerOverflowFlag |-> sequenceModeField == MODE_SINGLE
        && !halted) else $error("overflow on halt");
    halt_hold_a: assert property (halted && conversionEnable && $past(conversionEnable)
        |=> halted) else $error("halt left without recovery");
    hang_hold_a: assert property (hung |=> hung) else $error("hang cleared");
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the controller and converter pair
// Assumes: AXI master drives the controller, converter sits behind the link
// Notes: Expected values follow from mode, channel count and sample value
`timescale 1ns/10ps
module testbench import adcc_pkg::*; ;
    logic clock = 1'b0, reset = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [11:0] analogIn = 12'h000;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, lastResp;
    logic [31:0] rdata, got;
    int miscompares = 0, totalChecks = 0, seed = 77, dmaCount = 0, base;
    adcc_if link ();
    adcc_controller adcc_controller_inst (.clock, .reset, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .irq, .link(link.ctrl));
    adcc_device adcc_device_inst (.clock, .reset, .link(link.dev), .analogIn);
    adcc_link_checker adcc_link_checker_inst (.clock, .reset,
        .conversionEnable(link.conversionEnable), .converterPowerOn(link.converterPowerOn),
        .startConversion(link.startConversion), .timerTrigger(link.timerTrigger),
        .sequenceModeField(link.sequenceModeField),
        .conversionInProgress(link.conversionInProgress), .dmaRequest(link.dmaRequest),
        .triggerOverflowFlag(link.triggerOverflowFlag), .resultValid(link.resultValid),
        .halted(link.halted), .hung(link.hung));
    // Clock and result strobe count
    always #5 clock = ~clock;
    always @(posedge clock) if (link.dmaRequest === 1'b1) dmaCount++;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bus write: address and data together, response awaited
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 99);
        lastResp = bresp;
        if (bvalid !== 1'b1) begin
            chk("write timeout", 1, 0);
            stop_test();
        end
    endtask
    // Bus read: data and response taken at the answering edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 99);
        d = rdata;
        lastResp = rresp;
        if (rvalid !== 1'b1) begin
            chk("read timeout", 1, 0);
            stop_test();
        end
    endtask
    // Poll status until the masked bits match
    task automatic waitStat(input logic [31:0] m, input logic [31:0] v);
        logic [31:0] s;
        int n = 0;
        do begin
            rd(OFS_STATUS, s);
            n++;
        end while ((s & m) !== v && n < 200);
        chk("status", v, s & m);
        if ((s & m) !== v) stop_test();
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        // Reset value and an unmapped word
        rd(OFS_CTRL, got);
        chk("ctrl reset", CTRL_RESET, got);
        rd(8'h1C, got);
        chk("unmapped resp", RESP_SLVERR, lastResp);
        wr(8'h1C, 0);
        chk("unmapped wresp", RESP_SLVERR, lastResp);
        $display("test registers done");
        // Software start in single and sequence modes, last channel 3
        for (int m = 0; m < 2; m++) begin
            analogIn <= 12'($random(seed));
            base = dmaCount;
            wr(OFS_CTRL, 32'h0003_0007 | (32'(m) << 4));
            wr(OFS_CMD, 32'h0000_0001);
            waitStat(32'h0000_0021, 32'h0);
            chk("dma count", 32'(m * 3 + 1), 32'(dmaCount - base));
            rd(OFS_RESULT, got);
            chk("result", {16'h0, 4'(m * 3), analogIn}, got);
            $display("test mode %0d done", m);
        end
        // Done interrupt masked, unmasked, then cleared
        chk("irq masked", 32'h0, irq);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        chk("irq raised", 32'h1, irq);
        wr(OFS_IRQ_STAT, 32'h0000_000F);
        chk("irq cleared", 32'h0, irq);
        $display("test interrupt done");
        // Timer period shorter than a conversion in repeat mode, then recovery
        wr(OFS_PERIOD, 32'h0000_0005);
        wr(OFS_CTRL, 32'h0003_002F);
        waitStat(32'h0000_0002, 32'h0000_0002);
        wr(OFS_CTRL, 32'h0003_0027);
        wr(OFS_CMD, 32'h0000_0002);
        waitStat(32'h0000_0003, 32'h0);
        // Mode 0 overrun is flagged
        wr(OFS_CTRL, 32'h0003_000F);
        repeat (40) @(posedge clock);
        rd(OFS_IRQ_STAT, got);
        chk("overflow", 8, got & 8);
        $display("test halt and recovery done");
        stop_test();
    end
endmodule
